//--- ums_pkg.sv
/*
 pin logic constants and carriers for the two-channel serial/modem block.
 assumes one 50 MHz clock and byte-wide software registers.
*/
package ums_pkg;
    localparam int          NCH          = 2;     // channels a and b
    localparam int          AW           = 6;     // register address width
    localparam int          DW           = 8;     // register data width
    // register offsets, channel b adds the stride to the first four
    localparam logic [5:0]  CH_STRIDE    = 6'h10;
    localparam logic [5:0]  MCR_OFS      = 6'h00; // modem_ctrl_reg
    localparam logic [5:0]  EFR_OFS      = 6'h04; // enhanced_feature_reg
    localparam logic [5:0]  IER_OFS      = 6'h08; // irq_enable_reg
    localparam logic [5:0]  MSR_OFS      = 6'h0C; // pin state, read only
    localparam logic [5:0]  IRQ_STAT_OFS = 6'h20; // sticky events, w1c
    localparam logic [5:0]  IRQ_MASK_OFS = 6'h24; // event mask
    // modem_ctrl_reg fields
    localparam int          MCR_DTR      = 0;
    localparam int          MCR_RTS      = 1;
    localparam int          MCR_IR_INV   = 2;
    localparam int          MCR_OUT2     = 3;
    localparam int          MCR_IR       = 6;
    // enhanced_feature_reg fields
    localparam int          EFR_ARTS     = 6;
    localparam int          EFR_ACTS     = 7;
    // irq_enable_reg fields
    localparam int          IER_RTS      = 6;
    localparam int          IER_CTS      = 7;
    // event bits inside a channel nibble
    localparam int          EV_CTS       = 0;
    localparam int          EV_RTS       = 1;
    localparam int          EV_MODEM     = 2;
    localparam int          EV_SPARE     = 3;
    localparam int          EV_W         = 4;
    // reset values
    localparam logic [7:0]  MCR_RST      = 8'h00;
    localparam logic [7:0]  EFR_RST      = 8'h00;
    localparam logic [7:0]  IER_RST      = 8'h00;
    localparam logic [7:0]  STAT_RST     = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h00;

    // one register access from software
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ums_req_t;

    // pins sampled from the far side, one channel
    typedef struct packed {
        logic rx;
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } ums_pins_t;
endpackage : ums_pkg

//--- ums_serial_pins.sv
/*
 serial and modem-control pin logic for both channels of a dual uart,
 with register port, sticky event status and interrupt pins.
 assumes transmitter, infrared codec and receive fifo sit in the core,
 on the same clock, and that pins arrive asynchronously.
*/
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module ums_serial_pins (
    input  wire logic             mclk,
    input  wire logic             resetn,
    // register port
    input  wire ums_pkg::ums_req_t bus_req,
    output logic [7:0]            bus_rdata,
    // core side, channel a
    input  wire logic             tx_data_a,
    input  wire logic             tx_ir_a,
    input  wire logic             rx_halt_a,
    output logic                  rx_line_a,
    output logic                  tx_allow_a,
    // core side, channel b
    input  wire logic             tx_data_b,
    input  wire logic             tx_ir_b,
    input  wire logic             rx_halt_b,
    input  wire logic             rx_avail_b,
    output logic                  rx_line_b,
    output logic                  tx_allow_b,
    // pins, channel a
    output logic                  serial_out_chan_a,
    input  wire logic             serial_in_chan_a,
    output logic                  request_to_send_n_a,
    input  wire logic             clear_to_send_n_a,
    output logic                  terminal_ready_n_a,
    input  wire logic             set_ready_n_a,
    input  wire logic             carrier_detect_n_a,
    input  wire logic             ring_indicator_n_a,
    output logic                  output_port_two_n_a,
    output logic                  irq_out_chan_a,
    output logic                  irq_out_chan_a_oe,
    // pins, channel b
    output logic                  serial_out_chan_b,
    input  wire logic             serial_in_chan_b,
    output logic                  request_to_send_n_b,
    input  wire logic             clear_to_send_n_b,
    output logic                  terminal_ready_n_b,
    input  wire logic             set_ready_n_b,
    input  wire logic             carrier_detect_n_b,
    input  wire logic             ring_indicator_n_b,
    output logic                  output_port_two_n_b,
    output logic                  irq_out_chan_b,
    output logic                  irq_out_chan_b_oe,
    output logic                  rx_ready_n_chan_b,
    // combined interrupt level
    output logic                  irq
);
    import ums_pkg::*;

    // true when addr hits register ofs of channel ch
    function automatic logic hit(input logic [5:0] a, input int ch,
                                 input logic [5:0] ofs);
        logic [5:0] base;
        base = (ch == 0) ? 6'h00 : CH_STRIDE;
        hit = (a == (base | ofs));
    endfunction : hit

    logic [7:0]      modem_ctrl_reg        [NCH]; // modem_ctrl_reg per channel
    logic [7:0]      enhanced_feature_reg        [NCH]; // enhanced_feature_reg
    logic [7:0]      irq_enable_reg        [NCH]; // irq_enable_reg
    logic [7:0]      irq_stat;         // sticky events
    logic [7:0]      irq_mask;         // event mask
    logic [7:0]      ev;               // event pulses this cycle
    logic [7:0]      next_rdata;       // read mux
    ums_pins_t       pin_raw    [NCH]; // pins as they arrive
    ums_pins_t       pin_meta   [NCH]; // first sync stage
    ums_pins_t       pin_sync   [NCH]; // second sync stage
    ums_pins_t       pin_prev   [NCH]; // last synced value
    logic [NCH-1:0]  tx_data;          // core transmit level
    logic [NCH-1:0]  tx_ir;            // core encoder pulses
    logic [NCH-1:0]  rx_halt;          // fifo asks peer to stop
    logic [NCH-1:0]  serial_out;       // transmit pins
    logic [NCH-1:0]  rx_line;          // to receiver/decoder
    logic [NCH-1:0]  tx_allow;         // to transmitter
    logic [NCH-1:0]  rts_n;            // request pins
    logic [NCH-1:0]  dtr_n;            // terminal ready pins
    logic [NCH-1:0]  op2_n;            // output port 2 pins
    logic [NCH-1:0]  irq_val;          // channel interrupt level
    logic [NCH-1:0]  irq_oe;           // channel interrupt enable
    logic [NCH-1:0]  next_rts_n;       // rts value for next cycle

    // gather pins and core signals into arrays
    assign pin_raw[0] = '{rx: serial_in_chan_a, cts_n: clear_to_send_n_a,
                          dsr_n: set_ready_n_a, cd_n: carrier_detect_n_a,
                          ri_n: ring_indicator_n_a};
    assign pin_raw[1] = '{rx: serial_in_chan_b, cts_n: clear_to_send_n_b,
                          dsr_n: set_ready_n_b, cd_n: carrier_detect_n_b,
                          ri_n: ring_indicator_n_b};
    assign tx_data = {tx_data_b, tx_data_a};
    assign tx_ir   = {tx_ir_b, tx_ir_a};
    assign rx_halt = {rx_halt_b, rx_halt_a};

    // outputs straight from flops
    assign serial_out_chan_a   = serial_out[0];
    assign serial_out_chan_b   = serial_out[1];
    assign rx_line_a           = rx_line[0];
    assign rx_line_b           = rx_line[1];
    assign tx_allow_a          = tx_allow[0];
    assign tx_allow_b          = tx_allow[1];
    assign request_to_send_n_a = rts_n[0];
    assign request_to_send_n_b = rts_n[1];
    assign terminal_ready_n_a  = dtr_n[0];
    assign terminal_ready_n_b  = dtr_n[1];
    assign output_port_two_n_a = op2_n[0];
    assign output_port_two_n_b = op2_n[1];
    assign irq_out_chan_a      = irq_val[0];
    assign irq_out_chan_b      = irq_val[1];
    assign irq_out_chan_a_oe   = irq_oe[0];
    assign irq_out_chan_b_oe   = irq_oe[1];

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            // control registers written by software
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    modem_ctrl_reg[i] <= MCR_RST;
                    enhanced_feature_reg[i] <= EFR_RST;
                    irq_enable_reg[i] <= IER_RST;
                end
                else if (bus_req.wr)
                begin
                    if (hit(bus_req.addr, i, MCR_OFS))
                        modem_ctrl_reg[i] <= bus_req.wdata;
                    if (hit(bus_req.addr, i, EFR_OFS))
                        enhanced_feature_reg[i] <= bus_req.wdata;
                    if (hit(bus_req.addr, i, IER_OFS))
                        irq_enable_reg[i] <= bus_req.wdata;
                end
            end

            // two-stage sync, then change history
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pin_meta[i] <= '1;
                    pin_sync[i] <= '1;
                    pin_prev[i] <= '1;
                end
                else
                begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                    pin_prev[i] <= pin_sync[i];
                end
            end

            // transmit pin: level in standard mode, pulses in infrared
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    serial_out[i] <= 1'b1;
                else if (modem_ctrl_reg[i][MCR_IR])
                    serial_out[i] <= tx_ir[i];
                else
                    serial_out[i] <= tx_data[i];
            end

            // receive path towards receiver or decoder
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    rx_line[i] <= 1'b1;
                else if (modem_ctrl_reg[i][MCR_IR])
                    rx_line[i] <= pin_sync[i].rx ^ modem_ctrl_reg[i][MCR_IR_INV];
                else
                    rx_line[i] <= pin_sync[i].rx;
            end

            // rts follows its bit, auto mode also drops on fifo halt
            always_comb
            begin
                if (enhanced_feature_reg[i][EFR_ARTS])
                    next_rts_n[i] = ~modem_ctrl_reg[i][MCR_RTS] | rx_halt[i];
                else
                    next_rts_n[i] = ~modem_ctrl_reg[i][MCR_RTS];
            end

            // modem outputs and interrupt pin coupling
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    rts_n[i]    <= 1'b1;
                    dtr_n[i]    <= 1'b1;
                    op2_n[i]    <= 1'b1;
                    irq_oe[i]   <= 1'b0;
                    irq_val[i]  <= 1'b0;
                    tx_allow[i] <= 1'b1;
                end
                else
                begin
                    rts_n[i]    <= next_rts_n[i];
                    dtr_n[i]    <= ~modem_ctrl_reg[i][MCR_DTR];
                    op2_n[i]    <= ~modem_ctrl_reg[i][MCR_OUT2];
                    irq_oe[i]   <= modem_ctrl_reg[i][MCR_OUT2];
                    irq_val[i]  <= |(irq_stat[i*EV_W +: EV_W]
                                     & irq_mask[i*EV_W +: EV_W]);
                    // auto cts: transmit only while peer is clear
                    tx_allow[i] <= ~enhanced_feature_reg[i][EFR_ACTS]
                                   | ~pin_sync[i].cts_n;
                end
            end

            // event pulses for the sticky status
            assign ev[i*EV_W + EV_CTS]   = enhanced_feature_reg[i][EFR_ACTS] & irq_enable_reg[i][IER_CTS]
                & (pin_sync[i].cts_n != pin_prev[i].cts_n);
            assign ev[i*EV_W + EV_RTS]   = enhanced_feature_reg[i][EFR_ARTS] & irq_enable_reg[i][IER_RTS]
                & (next_rts_n[i] != rts_n[i]);
            // status inputs only flag a change, otherwise only read back at MSR_OFS
            assign ev[i*EV_W + EV_MODEM] =
                  (pin_sync[i].dsr_n != pin_prev[i].dsr_n)
                | (pin_sync[i].cd_n  != pin_prev[i].cd_n)
                | (pin_sync[i].ri_n  != pin_prev[i].ri_n);
            assign ev[i*EV_W + EV_SPARE] = 1'b0;
        end
    endgenerate

    // sticky status, new event wins over a clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            irq_stat <= STAT_RST;
        else if (bus_req.wr && bus_req.addr == IRQ_STAT_OFS)
            irq_stat <= (irq_stat & ~bus_req.wdata) | ev;
        else
            irq_stat <= irq_stat | ev;
    end

    // mask register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            irq_mask <= MASK_RST;
        else if (bus_req.wr && bus_req.addr == IRQ_MASK_OFS)
            irq_mask <= bus_req.wdata;
    end

    // combined interrupt level
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // receiver-ready for channel b, low while data waits
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rx_ready_n_chan_b <= 1'b1;
        else
            rx_ready_n_chan_b <= ~rx_avail_b;
    end

    // read mux, unmapped reads give zero
    always_comb
    begin
        next_rdata = 8'h00;
        for (int c = 0; c < NCH; c++)
        begin
            if (hit(bus_req.addr, c, MCR_OFS))
                next_rdata = modem_ctrl_reg[c];
            if (hit(bus_req.addr, c, EFR_OFS))
                next_rdata = enhanced_feature_reg[c];
            if (hit(bus_req.addr, c, IER_OFS))
                next_rdata = irq_enable_reg[c];
            if (hit(bus_req.addr, c, MSR_OFS))
                next_rdata = {3'h0, pin_sync[c]};
        end
        if (bus_req.addr == IRQ_STAT_OFS)
            next_rdata = irq_stat;
        if (bus_req.addr == IRQ_MASK_OFS)
            next_rdata = irq_mask;
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            bus_rdata <= 8'h00;
        else if (bus_req.rd)
            bus_rdata <= next_rdata;
        else
            bus_rdata <= 8'h00;
    end
endmodule : ums_serial_pins

//--- ums_chk_sva.sv
/*
 checker for the serial and modem pin block: pin levels against register writes.
 assumes only the top module ports, one clock domain, bound at the foot.
*/
`timescale 1ns/1ns
module ums_chk
    import ums_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire ums_pkg::ums_req_t bus_req,
    input wire logic              tx_data_a,
    input wire logic              tx_ir_a,
    input wire logic              rx_avail_b,
    input wire logic              serial_out_chan_a,
    input wire logic              serial_out_chan_b,
    input wire logic              request_to_send_n_a,
    input wire logic              terminal_ready_n_a,
    input wire logic              output_port_two_n_a,
    input wire logic              irq_out_chan_a_oe,
    input wire logic              output_port_two_n_b,
    input wire logic              irq_out_chan_b_oe,
    input wire logic              rx_ready_n_chan_b
);
    logic mcr_a_wr;  // write to channel a mode register
    assign mcr_a_wr = bus_req.wr && (bus_req.addr == MCR_OFS);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_op2_on;
        mcr_a_wr && bus_req.wdata[MCR_OUT2] |-> ##2 !output_port_two_n_a && irq_out_chan_a_oe;
    endproperty
    a_op2_on: assert property (p_op2_on) else $error("port two or irq drive wrong");
    property p_op2_off;
        mcr_a_wr && !bus_req.wdata[MCR_OUT2] |-> ##2 output_port_two_n_a && !irq_out_chan_a_oe;
    endproperty
    a_op2_off: assert property (p_op2_off) else $error("port two or irq float wrong");
    property p_op2_tie_b;
        output_port_two_n_b == !irq_out_chan_b_oe;
    endproperty
    a_op2_tie_b: assert property (p_op2_tie_b) else $error("b port two vs irq drive");
    property p_rxrdy;
        1'b1 |=> rx_ready_n_chan_b != $past(rx_avail_b);
    endproperty
    a_rxrdy: assert property (p_rxrdy) else $error("receiver ready pin wrong");
    property p_rts_clr;
        mcr_a_wr && !bus_req.wdata[MCR_RTS] |-> ##2 request_to_send_n_a;
    endproperty
    a_rts_clr: assert property (p_rts_clr) else $error("rts pin low with bit clear");
    property p_dtr;
        mcr_a_wr |-> ##2 terminal_ready_n_a != $past(bus_req.wdata[MCR_DTR], 2);
    endproperty
    a_dtr: assert property (p_dtr) else $error("terminal ready pin wrong");
    property p_tx_rst;
        $rose(resetn) |-> serial_out_chan_a && serial_out_chan_b;
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("transmit pin low in reset");
    property p_tx_std;
        mcr_a_wr && !bus_req.wdata[MCR_IR] ##1 tx_data_a |=> serial_out_chan_a;
    endproperty
    a_tx_std: assert property (p_tx_std) else $error("standard idle not high");
    property p_ir_idle;
        mcr_a_wr && bus_req.wdata[MCR_IR] ##1 !tx_ir_a |=> !serial_out_chan_a;
    endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");
endmodule : ums_chk

bind ums_serial_pins ums_chk chk_u (.mclk, .resetn, .bus_req, .tx_data_a, .tx_ir_a,
    .rx_avail_b, .serial_out_chan_a, .serial_out_chan_b, .request_to_send_n_a,
    .terminal_ready_n_a, .output_port_two_n_a, .irq_out_chan_a_oe, .output_port_two_n_b,
    .irq_out_chan_b_oe, .rx_ready_n_chan_b);

//--- ums_peer.sv
/*
 far side model: a remote serial device or modem on one channel.
 assumes the bench sets its stop and status levels.
*/
`timescale 1ns/1ns
module ums_peer (
    input  wire logic       mclk,
    input  wire logic       line_in,   // our transmit pin
    input  wire logic       stop,      // remote not ready for data
    input  wire logic [2:0] stat_n,    // dsr, cd, ri levels
    output logic            line_out,  // echo into our receive pin
    output logic            cts_n,
    output logic            dsr_n,
    output logic            cd_n,
    output logic            ri_n
);
    initial line_out = 1'b1;
    // remote echoes our line one clock later
    always @(posedge mclk)
    begin
        line_out <= line_in;
    end
    // grant sending unless stopped
    assign cts_n = stop;
    assign {dsr_n, cd_n, ri_n} = stat_n;
endmodule : ums_peer

//--- testbench.sv
/*
 testbench for the serial and modem pin block: register tasks and pin checks.
 assumes one 50 MHz clock and a remote peer model on each channel.
*/
`timescale 1ns/1ns
module testbench;
    import ums_pkg::*;
    logic mclk = 1'b0;
    logic resetn, tx_data_a, tx_ir_a, rx_halt_a, rx_line_a, tx_allow_a;
    logic tx_data_b, tx_ir_b, rx_halt_b, rx_avail_b, rx_line_b, tx_allow_b;
    logic serial_out_chan_a, serial_in_chan_a, request_to_send_n_a, clear_to_send_n_a;
    logic terminal_ready_n_a, set_ready_n_a, carrier_detect_n_a, ring_indicator_n_a;
    logic output_port_two_n_a, irq_out_chan_a, irq_out_chan_a_oe;
    logic serial_out_chan_b, serial_in_chan_b, request_to_send_n_b, clear_to_send_n_b;
    logic terminal_ready_n_b, set_ready_n_b, carrier_detect_n_b, ring_indicator_n_b;
    logic output_port_two_n_b, irq_out_chan_b, irq_out_chan_b_oe, rx_ready_n_chan_b, irq;
    ums_req_t   bus_req;
    logic [7:0] bus_rdata;
    logic       stop_a, stop_b;
    logic [2:0] stat_a, stat_b;
    logic [3:0] pins;
    logic [5:0] base;
    logic [7:0] pat [4] = '{8'h0B, 8'h00, 8'h08, 8'h03};
    int         errors, tests_run, cyc;

    always #10 mclk = ~mclk;

    ums_serial_pins dut_u (.*);
    ums_peer peer_a (.mclk(mclk), .line_in(serial_out_chan_a), .stop(stop_a), .stat_n(stat_a),
        .line_out(serial_in_chan_a), .cts_n(clear_to_send_n_a), .dsr_n(set_ready_n_a),
        .cd_n(carrier_detect_n_a), .ri_n(ring_indicator_n_a));
    ums_peer peer_b (.mclk(mclk), .line_in(serial_out_chan_b), .stop(stop_b), .stat_n(stat_b),
        .line_out(serial_in_chan_b), .cts_n(clear_to_send_n_b), .dsr_n(set_ready_n_b),
        .cd_n(carrier_detect_n_b), .ri_n(ring_indicator_n_b));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one write cycle on the register port
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask : wr

    // one read cycle, data taken in the following cycle
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1 chk(bus_rdata, exp);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            end_sim();
        end
    end

    initial
    begin
        resetn = 1'b0; bus_req = '0; tx_data_a = 1'b1; tx_data_b = 1'b1; tx_ir_a = 1'b0;
        tx_ir_b = 1'b0; rx_halt_a = 1'b0; rx_halt_b = 1'b0; rx_avail_b = 1'b0;
        stop_a = 1'b0; stop_b = 1'b0; stat_a = 3'b111; stat_b = 3'b111;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        tick(1);
        chk(serial_out_chan_b, 1'b1);
        chk({output_port_two_n_a, irq_out_chan_a_oe}, 2'b10);
        chk({request_to_send_n_b, terminal_ready_n_b}, 2'b11);
        rdc(6'h3F, 8'h00);
        // mode register walk over both channels
        for (int i = 0; i < 4; i++)
            for (int c = 0; c < 2; c++)
            begin
                base = c ? CH_STRIDE : 6'h00;
                wr(base + MCR_OFS, pat[i]);
                tick(2);
                pins = c ? {request_to_send_n_b, terminal_ready_n_b, output_port_two_n_b,
                    irq_out_chan_b_oe} : {request_to_send_n_a, terminal_ready_n_a,
                    output_port_two_n_a, irq_out_chan_a_oe};
                chk(pins, {~pat[i][1], ~pat[i][0], ~pat[i][3], pat[i][3]});
                rdc(base + MCR_OFS, pat[i]);
            end
        // standard then infrared line levels, echoed back by the peer
        tx_data_a <= 1'b0;
        tick(6);
        chk({serial_out_chan_a, rx_line_a}, 2'b00);
        tx_data_a <= 1'b1;
        wr(MCR_OFS, 8'h40);
        tick(6);
        chk({serial_out_chan_a, rx_line_a}, 2'b00);
        tx_ir_a <= 1'b1;
        tick(6);
        chk({serial_out_chan_a, rx_line_a}, 2'b11);
        tx_ir_a <= 1'b0;
        wr(MCR_OFS, 8'h44);
        tick(6);
        chk({serial_out_chan_a, rx_line_a}, 2'b01);
        // status inputs raise only the modem event
        wr(MCR_OFS, 8'h08);
        wr(IRQ_MASK_OFS, 8'h04);
        stat_a <= 3'b011;
        tick(6);
        rdc(MSR_OFS, 8'h13);
        chk({rx_line_a, tx_allow_a, irq, irq_out_chan_a}, 4'hF);
        rdc(IRQ_STAT_OFS, 8'h04);
        wr(IRQ_MASK_OFS, 8'h00);
        tick(2);
        chk(irq, 1'b0);
        wr(IRQ_STAT_OFS, 8'h04);
        rdc(IRQ_STAT_OFS, 8'h00);
        // clear-to-send gating and its event
        wr(EFR_OFS, 8'h80);
        wr(IER_OFS, 8'h80);
        wr(IRQ_MASK_OFS, 8'h01);
        stop_a <= 1'b1;
        tick(6);
        chk({tx_allow_a, irq}, 2'b01);
        stop_a <= 1'b0;
        tick(6);
        chk(tx_allow_a, 1'b1);
        wr(IRQ_STAT_OFS, 8'h01);
        // automatic request-to-send on channel b, bit set first
        wr(CH_STRIDE + MCR_OFS, 8'h02);
        wr(CH_STRIDE + IER_OFS, 8'h40);
        wr(CH_STRIDE + EFR_OFS, 8'h40);
        rx_halt_b <= 1'b1;
        tick(3);
        chk(request_to_send_n_b, 1'b1);
        rx_halt_b <= 1'b0;
        tick(3);
        chk(request_to_send_n_b, 1'b0);
        rdc(IRQ_STAT_OFS, 8'h20);
        // channel b interrupt pin, peer stop ignored without auto cts
        wr(IRQ_MASK_OFS, 8'h20);
        stop_b <= 1'b1;
        tick(6);
        chk({irq_out_chan_b, irq, tx_allow_b, rx_line_b}, 4'hF);
        rx_avail_b <= 1'b1;
        tick(2);
        chk(rx_ready_n_chan_b, 1'b0);
        end_sim();
    end
endmodule : testbench
